// File: pkg/pulse_seq_pkg.sv
// Constants and types shared by the phase pulse sequencer.
// Assumes a 100 MHz system clock; all inputs are synchronous to it.
package pulse_seq_pkg;
  localparam int NUM_PHASES = 6;
  localparam int CLK_PERIOD_NS = 10;
  // Power-up timing from the 3.3 V rail good
  localparam int STRAP_DONE_US = 1200;
  localparam int BUS_READY_US = 1500;
  localparam int STRAP_DONE_CYC = (STRAP_DONE_US * 1000) / CLK_PERIOD_NS;
  localparam int BUS_READY_CYC = (BUS_READY_US * 1000) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 18;
  // Current monitor scaling: full scale code equals 0.85 V
  localparam int MON_W = 10;
  localparam int IMAX_W = 12;
  localparam logic [MON_W-1:0] MON_FULL_SCALE = 10'h352; // 0.85 V in mV
  localparam int IOUT_W = 12;
  localparam int SENSE_W = 10;
  localparam int SUM_W = 13;
  localparam int PH_IDX_W = 3;
  localparam logic [PH_IDX_W-1:0] FIRST_PHASE = 3'h0;
  localparam logic [NUM_PHASES-1:0] PHASES_RESET = 6'h01;
  // Per-phase output drive
  typedef enum logic [1:0] {DRV_LOW, DRV_HIGH, DRV_TRISTATE} phase_drive_e;
  typedef enum {POR_WAIT_RAIL, POR_STRAP, POR_BUS_WAIT, POR_READY} por_state_e;
endpackage : pulse_seq_pkg

// File: pkg/phase_if.sv
// Carrier between the sequencer top and its phase steering module.
// Assumes all signals are in the sys_clk domain.
`timescale 1ns/10ps
interface phase_if;
  logic trigger;
  logic [pulse_seq_pkg::NUM_PHASES-1:0] active;
  logic single;
  logic overlap;
  logic [pulse_seq_pkg::NUM_PHASES-1:0] select;
  modport steer (input trigger, input active, input single, input overlap, output select);
  modport top (output trigger, output active, output single, output overlap, input select);
endinterface : phase_if

// File: hdl/phase_steer.sv
// Phase rotation: turns each switching trigger into a one-hot phase pick.
// Assumes phase 0 is always active and triggers are single-cycle pulses.
`timescale 1ns/10ps
module phase_steer (
  input wire logic sys_clk,
  input wire logic rst_b,
  phase_if.steer pif
);
  logic [pulse_seq_pkg::PH_IDX_W-1:0] ptr_reg;
  logic [pulse_seq_pkg::PH_IDX_W-1:0] ptr_next;
  logic [pulse_seq_pkg::PH_IDX_W-1:0] nxt_active;
  logic [pulse_seq_pkg::PH_IDX_W-1:0] pick;

  // First active phase at or after the given index, wrapping to phase 0
  function automatic logic [pulse_seq_pkg::PH_IDX_W-1:0] first_active(
    input logic [pulse_seq_pkg::PH_IDX_W-1:0] cur,
    input logic [pulse_seq_pkg::NUM_PHASES-1:0] act);
    logic [pulse_seq_pkg::PH_IDX_W-1:0] res;
    logic found;
    res = pulse_seq_pkg::FIRST_PHASE;
    found = 1'b0;
    for (int i = 0; i < pulse_seq_pkg::NUM_PHASES; i++) begin
      if (!found && i >= int'(cur) && act[i]) begin
        res = pulse_seq_pkg::PH_IDX_W'(i);
        found = 1'b1;
      end
    end
    return res;
  endfunction : first_active

  // A pointer left on a phase that was just disabled moves on before use
  assign pick = pif.single ? pulse_seq_pkg::FIRST_PHASE :
                first_active(ptr_reg, pif.active);
  assign nxt_active = first_active(pick + 3'h1, pif.active);
  assign ptr_next = pif.trigger ? nxt_active : pick;

  // One trigger, one phase
  generate
    for (genvar g = 0; g < pulse_seq_pkg::NUM_PHASES; g++) begin : g_sel
      assign pif.select[g] = pif.trigger && (pick == pulse_seq_pkg::PH_IDX_W'(g));
    end
  endgenerate

  // Pointer advances once per trigger
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ptr_reg <= pulse_seq_pkg::FIRST_PHASE;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  onehot_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pif.trigger |-> $onehot(pif.select)) else $error("trigger not steered to one phase");
  skip_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pif.trigger |-> (pif.select & ~pif.active) == '0) else $error("disabled phase chosen");
endmodule : phase_steer

// File: hdl/current_monitor.sv
// Current sum and scaled digital reading.
// Assumes per-phase sense samples are already digitised in sys_clk domain.
`timescale 1ns/10ps
module current_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [pulse_seq_pkg::NUM_PHASES*pulse_seq_pkg::SENSE_W-1:0] sense,
  input wire logic [pulse_seq_pkg::NUM_PHASES-1:0] active,
  input wire logic [pulse_seq_pkg::MON_W-1:0] mon_mv,
  input wire logic [pulse_seq_pkg::IMAX_W-1:0] imax,
  output logic [pulse_seq_pkg::SUM_W-1:0] sum_reg,
  output logic [pulse_seq_pkg::IOUT_W-1:0] iout_reg
);
  logic [pulse_seq_pkg::SUM_W-1:0] sum_next;
  logic [pulse_seq_pkg::IOUT_W+pulse_seq_pkg::MON_W-1:0] prod;
  logic [pulse_seq_pkg::IOUT_W+pulse_seq_pkg::MON_W-1:0] quot;

  // Sum only active channels
  always_comb begin
    sum_next = '0;
    for (int i = 0; i < pulse_seq_pkg::NUM_PHASES; i++) begin
      if (active[i]) begin
        sum_next = sum_next + pulse_seq_pkg::SUM_W'(sense[i*pulse_seq_pkg::SENSE_W +:
                                                     pulse_seq_pkg::SENSE_W]);
      end
    end
  end

  // Linear scaling; a divider is cheap here since it is read rarely
  assign prod = (pulse_seq_pkg::IOUT_W+pulse_seq_pkg::MON_W)'(imax) *
                (pulse_seq_pkg::IOUT_W+pulse_seq_pkg::MON_W)'(mon_mv);
  assign quot = prod / (pulse_seq_pkg::IOUT_W+pulse_seq_pkg::MON_W)'(pulse_seq_pkg::MON_FULL_SCALE);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sum_reg <= '0;
      iout_reg <= '0;
    end else begin
      sum_reg <= sum_next;
      iout_reg <= quot[pulse_seq_pkg::IOUT_W-1:0];
    end
  end

  full_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mon_mv == pulse_seq_pkg::MON_FULL_SCALE) |=> iout_reg == $past(imax))
    else $error("full scale reading wrong");
endmodule : current_monitor

// File: hdl/multiphase_pulse_sequencer.sv
// Top of the phase pulse sequencer: steering, transient modes, power-up.
// Assumes synchronous inputs; analog comparators sit outside and give levels.
//
// Summary of operation
// - A loop comparator trip starts an on-time pulse.
// - Each switching trigger yields exactly one pulse on exactly one phase.
// - In single-phase mode every trigger goes to the same phase.
// - In multiphase mode triggers rotate through the phases in fixed order.
// - Phases two to six whose sense input sits at the 3.3 V rail are disabled.
// - Each phase has its own current channel and channels are summed.
// - After the 3.3 V rail is good, strap reading completes in 1.2 ms.
// - Bus answers are allowed 1.5 ms after the 3.3 V rail is good.
// - Power-up sequencing does not wait for enable.
// - The current reading equals the maximum current at 0.85 V monitor.
// - The current reading is returned on the output-current read command.
// - Zero load line is chosen by resistor strap or by stored setting.
// - Overshoot reduction tri-states all phases once its threshold trips.
// - Overshoot reduction cuts any on pulse in progress at once.
// - Overlap of pulses is allowed only while undershoot condition holds.
// - When undershoot ends, normal interleaved rotation resumes.
`timescale 1ns/10ps
module multiphase_pulse_sequencer #(
  parameter int STRAP_CYCLES = pulse_seq_pkg::STRAP_DONE_CYC,
  parameter int BUS_CYCLES = pulse_seq_pkg::BUS_READY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic internal_3v3_rail,
  input wire logic enable,
  input wire logic loop_cmp_trip,
  input wire logic [pulse_seq_pkg::NUM_PHASES-1:0] phase_sense_at_rail,
  input wire logic [pulse_seq_pkg::NUM_PHASES*pulse_seq_pkg::SENSE_W-1:0] phase_current_sense_input,
  input wire logic [pulse_seq_pkg::MON_W-1:0] current_monitor_mv,
  input wire logic [pulse_seq_pkg::IMAX_W-1:0] imax_config,
  input wire logic overshoot_reduction_en,
  input wire logic overshoot_trip,
  input wire logic undershoot_reduction_en,
  input wire logic undershoot_trip,
  input wire logic on_time_done,
  input wire logic zero_ll_strap,
  input wire logic zero_ll_nvm,
  input wire logic zero_ll_use_nvm,
  input wire logic read_iout_cmd,
  output logic [pulse_seq_pkg::NUM_PHASES-1:0] phase_pwm_reg,
  output logic [pulse_seq_pkg::NUM_PHASES-1:0] phase_oe_reg,
  output logic [pulse_seq_pkg::SUM_W-1:0] current_sum_reg,
  output logic [pulse_seq_pkg::IOUT_W-1:0] iout_reply_reg,
  output logic iout_reply_valid_reg,
  output logic strap_done_reg,
  output logic bus_ready_reg,
  output logic zero_ll_reg,
  output logic undershoot_mode_reg
);
  phase_if pif();

  logic [pulse_seq_pkg::NUM_PHASES-1:0] active_phases;
  logic trip_reg;
  logic trigger;
  logic osr_active;
  logic usr_active;
  logic [pulse_seq_pkg::NUM_PHASES-1:0] pwm_next;
  logic [pulse_seq_pkg::NUM_PHASES-1:0] oe_next;
  logic [pulse_seq_pkg::IOUT_W-1:0] iout_val;
  logic [pulse_seq_pkg::POR_CNT_W-1:0] por_cnt_reg;
  logic [pulse_seq_pkg::POR_CNT_W-1:0] por_cnt_next;
  pulse_seq_pkg::por_state_e por_reg;
  pulse_seq_pkg::por_state_e por_next;
  logic running;
  logic [pulse_seq_pkg::POR_CNT_W-1:0] rail_age_reg;
  logic [pulse_seq_pkg::POR_CNT_W-1:0] rail_age_next;

  // Phase 0 cannot be disabled; others drop out when tied to the rail
  assign active_phases = {~phase_sense_at_rail[pulse_seq_pkg::NUM_PHASES-1:1], 1'b1};
  assign pif.active = active_phases;
  assign pif.single = (active_phases == pulse_seq_pkg::PHASES_RESET);

  // Rising edge of comparator gives one trigger per crossing
  assign running = (por_reg == pulse_seq_pkg::POR_READY) && enable;
  assign trigger = running && loop_cmp_trip && !trip_reg && !osr_active;
  assign pif.trigger = trigger;

  // Transient modes; overshoot has priority so both never act together
  assign osr_active = overshoot_reduction_en && overshoot_trip;
  assign usr_active = undershoot_reduction_en && undershoot_trip && !osr_active;
  assign pif.overlap = usr_active;

  phase_steer u_steer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pif(pif)
  );

  current_monitor u_mon (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sense(phase_current_sense_input),
    .active(active_phases),
    .mon_mv(current_monitor_mv),
    .imax(imax_config),
    .sum_reg(current_sum_reg),
    .iout_reg(iout_val)
  );

  // Pulse next state: a new pulse ends others unless overlap is allowed
  always_comb begin
    pwm_next = phase_pwm_reg;
    oe_next = active_phases;
    // Stages stay tri-stated while idle, so a pre-biased output is not pulled down
    if (!running || osr_active) begin
      pwm_next = '0;
      oe_next = '0;
    end else if (trigger) begin
      pwm_next = usr_active ? (phase_pwm_reg | pif.select) : pif.select;
    end else if (on_time_done) begin
      pwm_next = '0;
    end
  end

  // Power-up sequence runs from the rail alone, enable not involved
  always_comb begin
    por_next = por_reg;
    por_cnt_next = por_cnt_reg + 1'b1;
    unique case (por_reg)
      pulse_seq_pkg::POR_WAIT_RAIL: begin
        por_cnt_next = '0;
        if (internal_3v3_rail) begin
          por_next = pulse_seq_pkg::POR_STRAP;
        end
      end
      pulse_seq_pkg::POR_STRAP: begin
        if (por_cnt_reg == pulse_seq_pkg::POR_CNT_W'(STRAP_CYCLES - 1)) begin
          por_next = pulse_seq_pkg::POR_BUS_WAIT;
        end
      end
      pulse_seq_pkg::POR_BUS_WAIT: begin
        // Count runs on from the rail; a short bus count cannot hang here
        if (por_cnt_reg >= pulse_seq_pkg::POR_CNT_W'(BUS_CYCLES - 1)) begin
          por_next = pulse_seq_pkg::POR_READY;
        end
      end
      pulse_seq_pkg::POR_READY: begin
        por_cnt_next = por_cnt_reg;
      end
    endcase
    if (!internal_3v3_rail) begin
      por_next = pulse_seq_pkg::POR_WAIT_RAIL;
      por_cnt_next = '0;
    end
  end

  // Sequencing state and counters
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      por_reg <= pulse_seq_pkg::POR_WAIT_RAIL;
      por_cnt_reg <= '0;
    end else begin
      por_reg <= por_next;
      por_cnt_reg <= por_cnt_next;
    end
  end

  // Phase outputs and status flags
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trip_reg <= 1'b0;
      phase_pwm_reg <= '0;
      phase_oe_reg <= '0;
      strap_done_reg <= 1'b0;
      bus_ready_reg <= 1'b0;
      undershoot_mode_reg <= 1'b0;
    end else begin
      trip_reg <= loop_cmp_trip;
      phase_pwm_reg <= pwm_next;
      phase_oe_reg <= oe_next;
      strap_done_reg <= (por_next == pulse_seq_pkg::POR_BUS_WAIT) ||
                        (por_next == pulse_seq_pkg::POR_READY);
      bus_ready_reg <= (por_next == pulse_seq_pkg::POR_READY);
      undershoot_mode_reg <= usr_active;
    end
  end

  // Zero load line latched once straps are read; stored setting can override
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      zero_ll_reg <= 1'b0;
    end else if (por_reg == pulse_seq_pkg::POR_STRAP &&
                 por_next == pulse_seq_pkg::POR_BUS_WAIT) begin
      zero_ll_reg <= zero_ll_use_nvm ? zero_ll_nvm : zero_ll_strap;
    end
  end

  // Read reply only once the bus side is up
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      iout_reply_reg <= '0;
      iout_reply_valid_reg <= 1'b0;
    end else begin
      iout_reply_valid_reg <= read_iout_cmd && bus_ready_reg;
      if (read_iout_cmd && bus_ready_reg) begin
        iout_reply_reg <= iout_val;
      end
    end
  end

  // Cycles since the rail came good, kept apart from the sequencer; saturates
  assign rail_age_next = (rail_age_reg == '1) ? rail_age_reg : rail_age_reg + 1'b1;
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !internal_3v3_rail) begin
      rail_age_reg <= '0;
    end else begin
      rail_age_reg <= rail_age_next;
    end
  end

  osr_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    osr_active |=> (phase_oe_reg == '0 && phase_pwm_reg == '0))
    else $error("overshoot did not tri-state");
  osr_cut_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($past(phase_pwm_reg) != '0 && osr_active) |=> phase_pwm_reg == '0)
    else $error("pulse not cut");
  trigger_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    trigger |=> $countones(phase_pwm_reg & ~$past(phase_pwm_reg)) <= 1)
    else $error("trigger did not start one pulse");
  start_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    trigger |=> phase_pwm_reg != '0) else $error("no pulse on trigger");
  no_overlap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !$past(usr_active) |-> $countones(phase_pwm_reg) <= 1)
    else $error("overlap outside undershoot");
  usr_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(usr_active) |=> !undershoot_mode_reg) else $error("undershoot mode stuck");
  bus_early_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (por_reg != pulse_seq_pkg::POR_READY) |=> !bus_ready_reg || $past(por_next ==
      pulse_seq_pkg::POR_READY)) else $error("bus ready too early");
  strap_order_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus_ready_reg |-> strap_done_reg) else $error("bus ready before straps");
  single_same_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (trigger && pif.single) |-> pif.select[0]) else $error("single phase misrouted");
  reply_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (read_iout_cmd && bus_ready_reg) |=> iout_reply_valid_reg && iout_reply_reg == $past(iout_val))
    else $error("current read reply wrong");

  // Power-up milestones at fixed distances from the rail
  strap_time_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(strap_done_reg) |-> rail_age_reg == pulse_seq_pkg::POR_CNT_W'(STRAP_CYCLES + 1))
    else $error("strap time wrong");
  bus_time_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(bus_ready_reg) |-> rail_age_reg == pulse_seq_pkg::POR_CNT_W'(BUS_CYCLES + 1))
    else $error("bus ready time wrong");
  rail_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (por_reg == pulse_seq_pkg::POR_WAIT_RAIL && internal_3v3_rail) |=>
      por_reg == pulse_seq_pkg::POR_STRAP) else $error("power-up waited");
  rail_loss_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !internal_3v3_rail |=> (!strap_done_reg && !bus_ready_reg))
    else $error("status kept without rail");
  strap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (strap_done_reg && internal_3v3_rail) |=> strap_done_reg)
    else $error("strap done dropped");
  ready_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (bus_ready_reg && internal_3v3_rail) |=> bus_ready_reg)
    else $error("bus ready dropped");
  reply_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !bus_ready_reg |=> !iout_reply_valid_reg) else $error("reply before bus ready");
  zl_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(strap_done_reg) |->
      zero_ll_reg == $past(zero_ll_use_nvm ? zero_ll_nvm : zero_ll_strap))
    else $error("zero load line source wrong");

  // Phase outputs outside a trigger
  idle_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !running |=> (phase_pwm_reg == '0 && phase_oe_reg == '0))
    else $error("phases driven while idle");
  oe_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (running && !osr_active) |=> phase_oe_reg == $past(active_phases))
    else $error("phase enables wrong");
  trip_once_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    trigger |=> !trigger) else $error("one crossing gave two triggers");
  on_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (running && !osr_active && !trigger && on_time_done) |=> phase_pwm_reg == '0)
    else $error("pulse outlived on-time");
  usr_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    undershoot_mode_reg |-> $past(undershoot_reduction_en && undershoot_trip))
    else $error("undershoot mode without cause");
endmodule : multiphase_pulse_sequencer

// File: test/stage_model.sv
// Behavioural power stages and on-time generator beyond the phase outputs.
// Assumes the sys_clk domain and pwm from the sequencer.
`timescale 1ns/10ps
module stage_model #(
  parameter int ON_CYC = 6
) (
  input wire logic sys_clk,
  input wire logic [pulse_seq_pkg::NUM_PHASES-1:0] pwm,
  output logic on_done,
  output logic [pulse_seq_pkg::NUM_PHASES*pulse_seq_pkg::SENSE_W-1:0] sense
);
  int on_cnt = 0;
  // Fixed on-time; one done ends every pulse in flight, overlaps too
  always @(posedge sys_clk) on_cnt <= (|pwm === 1'b1) ? on_cnt + 1 : 0;
  assign on_done = (on_cnt >= ON_CYC);
  // Own sense channel per stage, phase i reports (i+1)*16
  always_comb begin
    for (int i = 0; i < pulse_seq_pkg::NUM_PHASES; i++) begin
      sense[i*10 +: 10] = 10'((i + 1) * 16);
    end
  end
endmodule : stage_model

// File: test/testbench.sv
// Self-checking bench for the phase pulse sequencer.
// Assumes short power-up counts; the stage model closes each pulse.
`timescale 1ns/10ps
module testbench;
  localparam int STRAP = 20;
  localparam int BUS = 30;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rail = 1'b0, enable = 1'b0, trip = 1'b0, ost = 1'b0, ust = 1'b0;
  logic ust_en = 1'b1, zl_s = 1'b0, zl_n = 1'b0, zl_use = 1'b0, rd = 1'b0, ost_en = 1'b1;
  logic [5:0] at_rail = 6'h00;
  logic [9:0] mv = 10'h000;
  logic [11:0] imax = 12'h000;
  logic on_done, iv, sd, br, zl, usm;
  logic [59:0] sense;
  logic [5:0] pwm, oe;
  logic [12:0] sum;
  logic [11:0] iout;
  int err_total = 0;
  int total_checks = 0;
  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  multiphase_pulse_sequencer #(.STRAP_CYCLES(STRAP), .BUS_CYCLES(BUS)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .internal_3v3_rail(rail), .enable(enable),
    .loop_cmp_trip(trip), .phase_sense_at_rail(at_rail),
    .phase_current_sense_input(sense), .current_monitor_mv(mv), .imax_config(imax),
    .overshoot_reduction_en(ost_en), .overshoot_trip(ost),
    .undershoot_reduction_en(ust_en), .undershoot_trip(ust), .on_time_done(on_done),
    .zero_ll_strap(zl_s), .zero_ll_nvm(zl_n), .zero_ll_use_nvm(zl_use),
    .read_iout_cmd(rd), .phase_pwm_reg(pwm), .phase_oe_reg(oe), .current_sum_reg(sum),
    .iout_reply_reg(iout), .iout_reply_valid_reg(iv), .strap_done_reg(sd),
    .bus_ready_reg(br), .zero_ll_reg(zl), .undershoot_mode_reg(usm));
  stage_model u_stage (.sys_clk(sys_clk), .pwm(pwm), .on_done(on_done), .sense(sense));
  // Verdict and value compare
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // A spent wait bound ends the run as a mismatch
  task automatic hang();
    chk(16'h0, 16'h1);
    give_verdict();
  endtask : hang
  task automatic wait_idle();
    int n = 0;
    while (pwm !== 6'h00) begin
      if (++n > 50) hang();
      tick(1);
    end
    tick(2);
  endtask : wait_idle
  // One comparator rise/fall; pwm judged one edge after the trip is seen
  task automatic fire(input logic [5:0] exp);
    @(posedge sys_clk) trip <= 1'b1;
    @(posedge sys_clk) trip <= 1'b0;
    tick(1);
    chk(16'(pwm), 16'(exp));
  endtask : fire
  // Rail-up sequencing with enable held low, bus refused early
  task automatic power_up(input logic s, input logic n, input logic u);
    int c = 0;
    @(posedge sys_clk) begin rail <= 1'b0; zl_s <= s; zl_n <= n; zl_use <= u; end
    tick(2);
    @(posedge sys_clk) begin rail <= 1'b1; rd <= 1'b1; end
    @(posedge sys_clk) rd <= 1'b0;
    while (sd !== 1'b1) begin
      if (iv === 1'b1) chk(16'h1, 16'h0);
      if (++c > 200) hang();
      tick(1);
    end
    chk(16'(c >= STRAP - 1 && c <= STRAP + 3), 16'h1);
    chk(16'(zl), 16'(u ? n : s));
    c = 0;
    while (br !== 1'b1) begin
      if (++c > 200) hang();
      tick(1);
    end
    chk(16'(c >= BUS - STRAP - 1 && c <= BUS - STRAP + 3), 16'h1);
  endtask : power_up
  // Full rotation twice, then skipped and single-phase rotation
  task automatic rotation();
    logic [5:0] seq[7] = '{6'h01, 6'h04, 6'h10, 6'h01, 6'h01, 6'h01, 6'h01};
    @(posedge sys_clk) enable <= 1'b1;
    tick(2);
    chk(16'(oe), 16'h003f);
    for (int i = 0; i < 12; i++) begin
      fire(6'h01 << (i % 6));
      wait_idle();
    end
    @(posedge sys_clk) at_rail <= 6'h2a;
    tick(1);
    chk(16'(oe), 16'h0015);
    for (int i = 0; i < 7; i++) begin
      if (i == 4) @(posedge sys_clk) at_rail <= 6'h3e;
      fire(seq[i]);
      wait_idle();
    end
    @(posedge sys_clk) begin at_rail <= 6'h00; enable <= 1'b0; end
    fire(6'h00);
    @(posedge sys_clk) enable <= 1'b1;
    tick(2);
  endtask : rotation
  // Trip ignored while disabled; then pulse cut mid on-time, triggers refused
  task automatic overshoot();
    @(posedge sys_clk) begin ost <= 1'b1; ost_en <= 1'b0; end
    fire(6'h01);
    @(posedge sys_clk) ost_en <= 1'b1;
    tick(2);
    chk(16'(pwm), 16'h0);
    chk(16'(oe), 16'h0);
    fire(6'h00);
    @(posedge sys_clk) ost <= 1'b0;
    tick(2);
    wait_idle();
  endtask : overshoot
  // Overlap only inside the undershoot window
  task automatic undershoot();
    @(posedge sys_clk) begin ust <= 1'b1; ust_en <= 1'b0; end
    tick(2);
    chk(16'(usm), 16'h0);
    @(posedge sys_clk) ust_en <= 1'b1;
    tick(2);
    chk(16'(usm), 16'h1);
    fire(6'h02);
    fire(6'h06);
    wait_idle();
    @(posedge sys_clk) ust <= 1'b0;
    tick(2);
    chk(16'(usm), 16'h0);
    fire(6'h08);
    fire(6'h10);
    wait_idle();
  endtask : undershoot
  // Reading request and reply
  task automatic read_chk(input logic [9:0] v, input logic [11:0] exp);
    int n = 0;
    @(posedge sys_clk) begin mv <= v; imax <= 12'h3e8; end
    tick(2);
    @(posedge sys_clk) rd <= 1'b1;
    @(posedge sys_clk) rd <= 1'b0;
    #1;
    while (iv !== 1'b1) begin
      if (++n > 4) hang();
      tick(1);
    end
    chk(16'(iout), 16'(exp));
  endtask : read_chk
  // Channel sum over active phases, then scaled readings
  task automatic monitor();
    tick(3);
    chk(16'(sum), 16'h0150);
    @(posedge sys_clk) at_rail <= 6'h2a;
    tick(3);
    chk(16'(sum), 16'h0090);
    read_chk(10'h352, 12'h3e8);
    read_chk(10'h1a9, 12'h1f4);
  endtask : monitor
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick(1);
    chk(16'({pwm, oe, sd, br, iv}), 16'h0);
    power_up(1'b1, 1'b0, 1'b0);
    power_up(1'b1, 1'b0, 1'b1);
    rotation();
    overshoot();
    undershoot();
    monitor();
    give_verdict();
  end
endmodule : testbench
